// ### include/prot_pkg.sv
package prot_pkg;
  // Stage status encoding
  typedef enum logic [1:0] {
    st_idle    = 2'b00,
    st_blocked = 2'b01,
    st_start   = 2'b10,
    st_trip    = 2'b11
  } stage_status_t;

  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned NUM_GROUPS      = 4;
  localparam int unsigned NUM_STAGES      = 32;
  localparam int unsigned MAX_ENABLED     = 30;
  localparam int unsigned NUM_RELAYS      = 6;
  localparam int unsigned SAMPLES_PER_PER = 32;
  // Half second force pulse, five minute panel timeout
  localparam int unsigned FORCE_MS        = 500;
  localparam int unsigned FORCE_CYCLES    = CLK_HZ / 1000 * FORCE_MS;
  localparam int unsigned IDLE_MIN        = 5;
  localparam longint unsigned IDLE_CYCLES = longint'(CLK_HZ) * 60 * IDLE_MIN;
  localparam logic PRIO_ASCENDING         = 1'b0;
endpackage

// ### include/stage_if.sv
`timescale 1ns/10ps
interface stage_if #(parameter int N = 32);
  logic [N-1:0] fault;     // Fault detected
  logic [N-1:0] delay_done;// Operation delay elapsed
  logic [N-1:0] block;     // Combined blocking
  logic [N-1:0] enable;    // Stage enabled
  logic [N-1:0] force_start;
  logic [N-1:0] force_trip;
  logic [2*N-1:0] status;  // Packed status per stage
  modport ctrl (output fault, delay_done, block, enable, force_start, force_trip,
                input status);
  modport stat (input fault, delay_done, block, enable, force_start, force_trip,
                output status);
endinterface

// ### src/stage_status.sv
`timescale 1ns/10ps
module stage_status #(
  parameter int N = 32
) (
  input  wire logic core_clk, // System clock
  input  wire logic reset,    // Sync reset
  stage_if.stat     s         // Stage signals
);
  logic [2*N-1:0] status_d;
  logic [2*N-1:0] status_q;

  // A disabled stage idles first, then forced states win; blocking only holds back a stage not yet tripping
  always_comb
  begin
    status_d = status_q;
    for (int i = 0; i < N; i++)
    begin
      if (!s.enable[i])
        status_d[2*i +: 2] = prot_pkg::st_idle;
      else if (s.force_trip[i])
        status_d[2*i +: 2] = prot_pkg::st_trip;
      else if (s.force_start[i])
        status_d[2*i +: 2] = prot_pkg::st_start;
      else if (!s.fault[i])
        status_d[2*i +: 2] = prot_pkg::st_idle;
      else if (status_q[2*i +: 2] == prot_pkg::st_trip)
        status_d[2*i +: 2] = prot_pkg::st_trip;
      else if (s.block[i])
        status_d[2*i +: 2] = prot_pkg::st_blocked;
      else if (s.delay_done[i])
        status_d[2*i +: 2] = prot_pkg::st_trip;
      else
        status_d[2*i +: 2] = prot_pkg::st_start;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
      status_q <= '0;
    else
      status_q <= status_d;
  end

  assign s.status = status_q;
endmodule

// ### src/protection_stage_group_select.sv
`timescale 1ns/10ps
module protection_stage_group_select #(
  parameter int          N_DI         = 16,
  parameter int          N_VI         = 4,
  parameter int          N_ST         = prot_pkg::NUM_STAGES,
  parameter int unsigned MAX_EN       = prot_pkg::MAX_ENABLED,
  parameter int unsigned SAMPLES      = prot_pkg::SAMPLES_PER_PER,
  parameter int unsigned FORCE_CYC    = prot_pkg::FORCE_CYCLES,
  parameter longint unsigned IDLE_CYC = prot_pkg::IDLE_CYCLES,
  parameter int unsigned PERIOD_DEF   = 2_000_000
) (
  input  wire logic                core_clk,           // 100 MHz clock
  input  wire logic                reset,              // Sync reset, active high
  input  wire logic [N_DI-1:0]     digital_inputs,     // Digital inputs
  input  wire logic [N_VI-1:0]     virtual_inputs,     // Panel/comm/logic inputs
  input  wire logic [4*6-1:0]      group_input_assignment, // Per group: src idx, 0 = none
  input  wire logic                group_priority_order, // 0 ascending, 1 descending
  input  wire logic [1:0]          idle_group_choice,  // Group when no input active
  output logic      [1:0]          active_group,       // Active group minus one
  input  wire logic                phase_one_zero_cross, // First phase current zero cross
  input  wire logic                phase_one_present,  // Current present on phase one
  input  wire logic [31:0]         configured_period,  // Mains period in cycles, fallback
  output logic                     sample_strobe,      // Sample tick
  output logic [31:0]              measured_period,    // Period in use
  input  wire logic [N_ST-1:0]     stage_enable_req,   // Requested stage enables
  output logic      [N_ST-1:0]     stage_enabled,      // Granted stage enables
  input  wire logic [N_ST-1:0]     stage_fault,        // Fault detected per stage
  input  wire logic [N_ST-1:0]     stage_delay_done,   // Delay elapsed per stage
  input  wire logic [N_ST-1:0]     block_matrix,       // Blocking from other stages
  input  wire logic [N_ST-1:0]     block_logic,        // Blocking from logic outputs
  input  wire logic [N_ST-1:0]     block_di,           // Blocking from digital inputs
  input  wire logic [N_ST-1:0]     block_internal,     // Stage own blocking
  output logic      [2*N_ST-1:0]   stage_status,       // Two bits per stage
  input  wire logic                force_flag_set,     // Pulse: raise force flag
  input  wire logic                panel_key,          // Panel key activity pulse
  output logic                     force_flag,         // Force flag level
  input  wire logic [N_ST-1:0]     force_start_req,    // Pulse: force start
  input  wire logic [N_ST-1:0]     force_trip_req,     // Pulse: force trip
  input  wire logic [prot_pkg::NUM_RELAYS-1:0] relay_normal, // Computed relays
  input  wire logic [prot_pkg::NUM_RELAYS-1:0] relay_force_en, // Relay force enable
  input  wire logic [prot_pkg::NUM_RELAYS-1:0] relay_force_val, // Relay forced value
  output logic      [prot_pkg::NUM_RELAYS-1:0] relay_out  // Trip1-4, signal, service
);
  // Source index 1..N_DI picks a digital input, N_DI+1..N_DI+N_VI a virtual one, any other none
  function automatic logic src_active(input logic [5:0] idx, input logic [N_DI-1:0] di,
                                      input logic [N_VI-1:0] vi);
    logic r;
    r = 1'b0;
    if (idx != 6'h00 && int'(idx) <= N_DI)
      r = di[int'(idx) - 1];
    else if (int'(idx) > N_DI && int'(idx) <= N_DI + N_VI)
      r = vi[int'(idx) - N_DI - 1];
    return r;
  endfunction

  logic [prot_pkg::NUM_GROUPS-1:0] grp_act;
  logic [1:0] group_d;
  logic [1:0] group_q;

  // Resolve the active group from assigned inputs
  always_comb
  begin
    for (int g = 0; g < prot_pkg::NUM_GROUPS; g++)
      grp_act[g] = src_active(group_input_assignment[6*g +: 6], digital_inputs,
                              virtual_inputs);
    group_d = idle_group_choice;
    if (group_priority_order == prot_pkg::PRIO_ASCENDING)
    begin
      for (int g = prot_pkg::NUM_GROUPS - 1; g >= 0; g--)
        if (grp_act[g])
          group_d = 2'(g);
    end
    else
    begin
      for (int g = 0; g < prot_pkg::NUM_GROUPS; g++)
        if (grp_act[g])
          group_d = 2'(g);
    end
  end

  // Period tracking: zero crossings measure period while current is present
  logic [31:0] pcnt_d, pcnt_q, per_d, per_q, scnt_d, scnt_q;
  logic        strobe_d, strobe_q;
  always_comb
  begin
    pcnt_d   = pcnt_q + 32'h1;
    per_d    = per_q;
    if (!phase_one_present)
      per_d = configured_period;
    else if (phase_one_zero_cross)
    begin
      per_d  = pcnt_q;
      pcnt_d = 32'h1;
    end
    // Sample interval is period / SAMPLES, shift since count is power of two
    scnt_d   = scnt_q + 32'h1;
    strobe_d = 1'b0;
    if (scnt_q >= (per_q >> $clog2(SAMPLES)) - 32'h1)
    begin
      scnt_d   = 32'h0;
      strobe_d = 1'b1;
    end
  end

  // Cap: lower-numbered requests win while room remains
  logic [N_ST-1:0] en_d, en_q;
  always_comb
  begin
    automatic int unsigned cnt;
    cnt  = 0;
    en_d = '0;
    for (int i = 0; i < N_ST; i++)
      if (stage_enable_req[i] && cnt < MAX_EN)
      begin
        en_d[i] = 1'b1;
        cnt++;
      end
  end

  // Force flag with panel-idle timeout
  logic        ff_d, ff_q;
  logic [39:0] idle_d, idle_q;
  logic [31:0] ftmr_d [N_ST];
  logic [31:0] ftmr_q [N_ST];
  logic [N_ST-1:0] ftrip_d, ftrip_q;
  always_comb
  begin
    ff_d   = ff_q;
    idle_d = idle_q;
    if (force_flag_set || panel_key)
      idle_d = 40'h0;
    else if (ff_q)
      idle_d = idle_q + 40'h1;
    if (force_flag_set)
      ff_d = 1'b1;
    // A key press in the expiry cycle still counts as activity and keeps the flag
    else if (ff_q && !panel_key && idle_q >= 40'(IDLE_CYC - 1))
      ff_d = 1'b0;
    for (int i = 0; i < N_ST; i++)
    begin
      ftmr_d[i]  = (ftmr_q[i] != 32'h0) ? ftmr_q[i] - 32'h1 : 32'h0;
      ftrip_d[i] = ftrip_q[i];
      if (!ff_d)
      begin
        ftmr_d[i]  = 32'h0;
        ftrip_d[i] = 1'b0;
      end
      else if (force_trip_req[i] || force_start_req[i])
      begin
        ftmr_d[i]  = FORCE_CYC;
        ftrip_d[i] = force_trip_req[i];
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      group_q  <= 2'h0;
      pcnt_q   <= 32'h0;
      per_q    <= PERIOD_DEF;
      scnt_q   <= 32'h0;
      strobe_q <= 1'b0;
      en_q     <= '0;
      ff_q     <= 1'b0;
      idle_q   <= 40'h0;
      ftrip_q  <= '0;
      for (int i = 0; i < N_ST; i++)
        ftmr_q[i] <= 32'h0;
    end
    else
    begin
      group_q  <= group_d;
      pcnt_q   <= pcnt_d;
      per_q    <= per_d;
      scnt_q   <= scnt_d;
      strobe_q <= strobe_d;
      en_q     <= en_d;
      ff_q     <= ff_d;
      idle_q   <= idle_d;
      ftrip_q  <= ftrip_d;
      for (int i = 0; i < N_ST; i++)
        ftmr_q[i] <= ftmr_d[i];
    end
  end

  // Stage status tracker
  stage_if #(.N(N_ST)) sif ();
  logic [N_ST-1:0] fst, ftr;
  always_comb
  begin
    for (int i = 0; i < N_ST; i++)
    begin
      fst[i] = ff_q && ftmr_q[i] != 32'h0 && !ftrip_q[i];
      ftr[i] = ff_q && ftmr_q[i] != 32'h0 && ftrip_q[i];
    end
  end
  assign sif.fault       = stage_fault;
  assign sif.delay_done  = stage_delay_done;
  assign sif.block       = block_matrix | block_logic | block_di | block_internal;
  assign sif.enable      = en_q;
  assign sif.force_start = fst;
  assign sif.force_trip  = ftr;

  stage_status #(.N(N_ST)) u_status (
    .core_clk (core_clk),
    .reset    (reset),
    .s        (sif.stat)
  );

  // Relay forcing only while the flag is up
  always_comb
  begin
    for (int r = 0; r < prot_pkg::NUM_RELAYS; r++)
      relay_out[r] = (ff_q && relay_force_en[r]) ? relay_force_val[r]
                                                : relay_normal[r];
  end

  assign active_group    = group_q;
  assign sample_strobe   = strobe_q;
  assign measured_period = per_q;
  assign stage_enabled   = en_q;
  assign stage_status    = sif.status;
  assign force_flag      = ff_q;
endmodule

// ### verif/psgs_sva.sv
`timescale 1ns/10ps
module psgs_sva #(
  parameter int              N_ST     = 32,
  parameter int unsigned     MAX_EN   = 30,
  parameter longint unsigned IDLE_CYC = 100
) (
  input wire logic            core_clk,               // Clock
  input wire logic            reset,                  // Sync reset
  input wire logic [23:0]     group_input_assignment, // Group sources
  input wire logic [1:0]      idle_group_choice,      // Fallback group
  input wire logic [1:0]      active_group,           // Selected group
  input wire logic [N_ST-1:0] stage_enable_req,       // Requested enables
  input wire logic [N_ST-1:0] stage_enabled,          // Granted enables
  input wire logic            force_flag_set,         // Raise flag
  input wire logic            panel_key,              // Panel activity
  input wire logic            force_flag,             // Flag level
  input wire logic [5:0]      relay_normal,           // Computed relays
  input wire logic [5:0]      relay_force_en,         // Force enables
  input wire logic [5:0]      relay_force_val,        // Forced values
  input wire logic [5:0]      relay_out               // Relay outputs
);
  logic [39:0] quiet_q;
  logic [39:0] quiet_d;
  wire  [5:0]  fmask = relay_force_en & {6{force_flag}};
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // Quiet time with the flag up; 40 bits so the full five-minute count fits
  always_comb quiet_d = (force_flag && !panel_key && !force_flag_set) ? quiet_q + 40'h1 : 40'h0;
  always_ff @(posedge core_clk) quiet_q <= reset ? 40'h0 : quiet_d;
  a_relay_force_mux: assert property
    (relay_out == ((relay_force_val & fmask) | (relay_normal & ~fmask)))
    else $error("relay output mux wrong");
  a_flag_raise: assert property (force_flag_set |=> force_flag)
    else $error("force flag not raised");
  a_flag_no_self: assert property (!force_flag && !force_flag_set |=> !force_flag)
    else $error("force flag rose by itself");
  // Exact bounds: the flag stands for exactly IDLE_CYC quiet cycles
  a_flag_keeps_up: assert property
    (force_flag && quiet_q < IDLE_CYC - 1 |=> force_flag)
    else $error("force flag dropped early");
  a_flag_expires: assert property (quiet_q <= IDLE_CYC)
    else $error("force flag never expired");
  a_enable_subset: assert property
    (1'b1 |=> (stage_enabled & ~$past(stage_enable_req)) == '0)
    else $error("unrequested stage enabled");
  a_enable_cap: assert property ($countones(stage_enabled) <= MAX_EN)
    else $error("too many stages enabled");
  a_enable_grant: assert property
    ($countones(stage_enable_req) <= MAX_EN |=> stage_enabled == $past(stage_enable_req))
    else $error("request under cap not granted");
  a_idle_group_used: assert property
    (group_input_assignment == 24'h0 |=> active_group == $past(idle_group_choice))
    else $error("fallback group not used");
  c_flag_up: cover property ($rose(force_flag));
  c_flag_down: cover property ($fell(force_flag));
  c_over_cap: cover property ($countones(stage_enable_req) > MAX_EN);
endmodule
bind protection_stage_group_select psgs_sva #(.N_ST(N_ST), .MAX_EN(MAX_EN), .IDLE_CYC(IDLE_CYC))
  psgs_sva_i (.core_clk, .reset, .group_input_assignment, .idle_group_choice, .active_group,
  .stage_enable_req, .stage_enabled, .force_flag_set, .panel_key, .force_flag, .relay_normal,
  .relay_force_en, .relay_force_val, .relay_out);

// ### verif/far_side_model.sv
`timescale 1ns/10ps
module far_side_model (
  input wire logic core_clk,       // Clock
  output logic [15:0] digital_inputs, // Field inputs
  output logic [3:0]  virtual_inputs, // Panel/comm inputs
  output logic        panel_key,      // Key activity pulse
  output logic        force_flag_set  // Flag raise pulse
);
  initial {digital_inputs, virtual_inputs, panel_key, force_flag_set} = 22'h0;
  // Input levels change just after an edge and then stand
  task automatic drive(input logic [15:0] di, input logic [3:0] vi);
    @(posedge core_clk);
    #1 {digital_inputs, virtual_inputs} = {di, vi};
  endtask
  // One-cycle pulse: either a flag raise or a plain key press
  task automatic press(input logic raise);
    @(posedge core_clk);
    #1 {force_flag_set, panel_key} = {raise, !raise};
    @(posedge core_clk);
    #1 {force_flag_set, panel_key} = 2'h0;
  endtask
endmodule

// ### verif/tb.sv
`timescale 1ns/10ps
module tb;
  logic        core_clk = 1'h0;
  logic        reset = 1'h1;
  logic [15:0] digital_inputs;
  logic [3:0]  virtual_inputs;
  logic [23:0] group_input_assignment = 24'h0;
  logic        group_priority_order = 1'h0;
  logic [1:0]  idle_group_choice = 2'h2;
  logic [1:0]  active_group;
  logic        sample_strobe, force_flag_set, panel_key, force_flag;
  logic [31:0] measured_period, stage_enabled;
  logic [31:0] configured_period = 32'h140;
  logic        phase_one_zero_cross = 1'h0, phase_one_present = 1'h0;
  logic [31:0] stage_enable_req = 32'h0, stage_fault = 32'h0, stage_delay_done = 32'h0;
  logic [31:0] block_matrix = 32'h0, block_logic = 32'h0, block_di = 32'h0;
  logic [31:0] block_internal = 32'h0, force_start_req = 32'h0, force_trip_req = 32'h0;
  logic [63:0] stage_status;
  logic [5:0]  relay_normal = 6'h15, relay_force_en = 6'h3F, relay_force_val = 6'h2A, relay_out;
  int          err_count = 0, compares = 0, cyc = 0, n;
  always #5 core_clk = ~core_clk;
  far_side_model far_side_model_i (.core_clk, .digital_inputs, .virtual_inputs, .panel_key,
    .force_flag_set);
  // Short force and idle counts keep the run brief
  protection_stage_group_select #(.FORCE_CYC(20), .IDLE_CYC(100), .PERIOD_DEF(320))
    protection_stage_group_select_i (.core_clk, .reset, .digital_inputs, .virtual_inputs,
    .group_input_assignment, .group_priority_order, .idle_group_choice, .active_group,
    .phase_one_zero_cross, .phase_one_present, .configured_period, .sample_strobe,
    .measured_period, .stage_enable_req, .stage_enabled, .stage_fault, .stage_delay_done,
    .block_matrix, .block_logic, .block_di, .block_internal, .stage_status, .force_flag_set,
    .panel_key, .force_flag, .force_start_req, .force_trip_req, .relay_normal, .relay_force_en,
    .relay_force_val, .relay_out);
  task automatic tick(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic test_groups();
    // No assignment at all: only the idle choice may steer the group
    tick(2);
    chk(active_group, 2'h2);
    idle_group_choice = 2'h1;
    tick(2);
    chk(active_group, 2'h1);
    group_input_assignment = {6'h04, 6'h03, 6'h02, 6'h05};
    far_side_model_i.drive(16'h0, 4'h0);
    tick(2);
    chk(active_group, 2'h1);
    far_side_model_i.drive(16'h0010, 4'h0);
    tick(2);
    chk(active_group, 2'h0);
    far_side_model_i.drive(16'h0006, 4'h0);
    tick(2);
    chk(active_group, 2'h1);
    group_priority_order = 1'h1;
    tick(2);
    chk(active_group, 2'h2);
    group_input_assignment[23:18] = 6'h11;
    far_side_model_i.drive(16'h0, 4'h1);
    tick(2);
    chk(active_group, 2'h3);
    $display("test groups done");
  endtask
  task automatic test_enable();
    stage_enable_req = 32'hFFFFFFFF;
    tick(2);
    chk(stage_enabled, 32'h3FFFFFFF);
    stage_enable_req = 32'h8000000D;
    tick(2);
    chk(stage_enabled, 32'h8000000D);
    $display("test enable done");
  endtask
  task automatic test_status();
    stage_enable_req = 32'h0000000F;
    stage_fault = 32'h1;
    tick(3);
    chk(stage_status[1:0], 2'h2);
    stage_delay_done = 32'h1;
    tick(3);
    chk(stage_status[1:0], 2'h3);
    stage_fault = 32'h3;
    for (int k = 0; k < 4; k++)
    begin
      {block_internal, block_di, block_logic, block_matrix} = 128'h3 << (32 * k);
      tick(3);
      chk(stage_status[3:0], 4'h7);
    end
    {stage_fault, stage_delay_done, block_internal} = 96'h0;
    tick(3);
    chk(stage_status[7:0], 8'h0);
    $display("test status done");
  endtask
  task automatic test_force();
    force_trip_req = 32'h4;
    tick(1);
    force_trip_req = 32'h0;
    tick(3);
    chk({stage_status[5:4], relay_out}, {2'h0, 6'h15});
    far_side_model_i.press(1'h1);
    chk({force_flag, relay_out}, {1'h1, 6'h2A});
    // Only relays 0 and 2 forced now; the rest follow their computed value
    force_trip_req = 32'h4;
    relay_force_en = 6'h05;
    tick(1);
    force_trip_req = 32'h0;
    tick(3);
    chk({stage_status[5:4], relay_out}, {2'h3, 6'h10});
    tick(17);
    chk(stage_status[5:4], 2'h3);
    tick(1);
    chk(stage_status[5:4], 2'h0);
    far_side_model_i.press(1'h0);
    tick(85);
    force_start_req = 32'h8;
    tick(1);
    force_start_req = 32'h0;
    tick(2);
    chk({force_flag, stage_status[7:6]}, {1'h1, 2'h2});
    tick(11);
    chk(force_flag, 1'h1);
    tick(1);
    chk({force_flag, relay_out}, {1'h0, 6'h15});
    tick(1);
    chk(stage_status[7:6], 2'h0);
    $display("test force done");
  endtask
  task automatic test_sample();
    n = 0;
    repeat (320)
    begin
      tick(1);
      n += (sample_strobe === 1'h1);
    end
    chk(n, 32'h20);
    chk(measured_period, 32'h140);
    // Zero crossings 256 cycles apart must retune the strobe to 32 per period
    phase_one_present = 1'h1;
    repeat (3)
    begin
      tick(255);
      phase_one_zero_cross = 1'h1;
      tick(1);
      phase_one_zero_cross = 1'h0;
    end
    n = 0;
    repeat (256)
    begin
      tick(1);
      n += (sample_strobe === 1'h1);
    end
    chk({measured_period, n}, {32'h100, 32'h20});
    // Without current the configured period takes over
    phase_one_present = 1'h0;
    configured_period = 32'h200;
    tick(1);
    chk(measured_period, 32'h200);
    $display("test sample done");
  endtask
  // Hang guard well above the expected run length
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      finish_test();
    end
  end
  initial
  begin
    repeat (16) @(posedge core_clk);
    #1 reset = 1'h0;
    test_groups();
    test_enable();
    test_status();
    test_force();
    test_sample();
    finish_test();
  end
endmodule
